// *** rtl/sefb_consts.svh ***
// Offsets, field positions and reset values of the status and flag bank.
// Assumes an 8-bit register address space reached by the serial port.
// How it works
// RQ1 - Second status register bit 7 shows input power good, 1 means good.
// RQ2 - Bits 6:4 carry thermistor zone: normal, warm, cool, cold, hot.
// RQ3 - Third status bits 5:4 show sync clock: none, valid, out of range.
// RQ4 - Third status bit 2 is set while the converter runs in reverse.
// RQ5 - Fault status bit 7 follows input under-voltage protection.
// RQ6 - Fault status bit 6 follows input over-voltage protection.
// RQ7 - Fault status bit 5 follows battery-side over-current detection.
// RQ8 - Fault status bit 4 follows battery-side over-voltage protection.
// RQ9 - Fault status bit 3 follows thermal shutdown protection.
// RQ10 - Fault status bit 1 shows gate-driver supply out of range.
// RQ11 - Battery-only with converter ADC off forces driver supply fault bit to 1.
// RQ12 - Reading a flag register clears every event flag in it.
// RQ13 - Conversion-complete flag sets only in one-shot mode, else reads 0.
// RQ14 - First flag bit 6 latches on entering input current regulation.
// RQ15 - First flag bit 5 latches on entering input voltage regulation.
// RQ16 - First flag bit 3 latches on a rising watchdog expiry status.
// RQ17 - Second flag bit 7 latches when power good toggles either way.
// RQ18 - Second flag bit 4 latches when the thermistor zone changes.
// RQ19 - Second flag bit 3 latches when reverse mode toggles.
// RQ20 - Second flag bit 1 latches when the sync status field changes.
// RQ21 - All five registers reset to zero.
// RQ22 - An unmasked flag set gives an interrupt pulse; mask 1 suppresses it.
// RQ23 - Watchdog expiry status reads 1 once expired; its rise sets the flag.
// RQ24 - Reserved bits read zero; writes to these registers do nothing.
// RQ25 - Flags hold until read, the conversion flag only while in one-shot mode; an event during the clearing read stays latched.
`ifndef SEFB_CONSTS_SVH
`define SEFB_CONSTS_SVH

`define SEFB_OFS_PG_TS   8'h22
`define SEFB_OFS_SYN_REV 8'h23
`define SEFB_OFS_FAULT   8'h24
`define SEFB_OFS_FLAG1   8'h25
`define SEFB_OFS_FLAG2   8'h26
`define SEFB_RST_VAL     8'h00

`define SEFB_B_PG        7
`define SEFB_B_TS_HI     6
`define SEFB_B_TS_LO     4
`define SEFB_B_SYN_HI    5
`define SEFB_B_SYN_LO    4
`define SEFB_B_REV       2
`define SEFB_B_UV        7
`define SEFB_B_OV        6
`define SEFB_B_BOC       5
`define SEFB_B_BOV       4
`define SEFB_B_TSH       3
`define SEFB_B_DRV       1
`define SEFB_B_ADC       7
`define SEFB_B_IAC       6
`define SEFB_B_VAC       5
`define SEFB_B_WD        3
`define SEFB_B_PGF       7
`define SEFB_B_TSF       4
`define SEFB_B_REVF      3
`define SEFB_B_SYNF      1

`endif

// *** rtl/sefb_pkg.sv ***
// Types shared by the status and flag bank.
// Assumes nothing beyond the constants header.
package sefb_pkg;

  typedef enum logic [2:0] {
    TS_NORMAL = 3'h0,
    TS_WARM   = 3'h1,
    TS_COOL   = 3'h2,
    TS_COLD   = 3'h3,
    TS_HOT    = 3'h4
  } sefb_ts_zone_t;

  typedef enum logic [1:0] {
    SYN_NONE  = 2'h0,
    SYN_VALID = 2'h1,
    SYN_FAULT = 2'h2
  } sefb_sync_t;

  // Raw levels from the analog and protection circuitry
  typedef struct packed {
    logic          powerGood;
    sefb_ts_zone_t tsZone;
    sefb_sync_t    syncState;
    logic          reverseOn;
    logic          inUv;
    logic          inOv;
    logic          batOc;
    logic          batOv;
    logic          tshut;
    logic          drvFault;
    logic          battOnlyAdcOff;
    logic          adcDone;
    logic          oneShot;
    logic          iacReg;
    logic          vacReg;
    logic          wdExpired;
  } sefb_stat_in_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
  } sefb_rd_req_t;

endpackage : sefb_pkg

// *** rtl/sefb_status_flag_bank.sv ***
// Read-only status registers and clear-on-read event flags.
// Assumes a serial port engine on core_clk issuing one-cycle read strobes,
// and mask bits from the mask registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sefb_consts.svh"

module sefb_status_flag_bank (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire sefb_pkg::sefb_stat_in_t statIn,
  input  wire sefb_pkg::sefb_rd_req_t  rdReq,
  input  wire logic [7:0]             flagMask1,
  input  wire logic [7:0]             flagMask2,
  output var  logic [7:0]             rdData_q,
  output var  logic                   rdValid_q,
  output var  logic                   irqPulse_q
);

  localparam int SW = $bits(sefb_pkg::sefb_stat_in_t);

  logic [SW-1:0]           syncA_q;
  logic [SW-1:0]           syncB_q;
  sefb_pkg::sefb_stat_in_t st;
  sefb_pkg::sefb_stat_in_t prev_q;
  logic [7:0]              stat2_q;
  logic [7:0]              stat3_q;
  logic [7:0]              fault_q;
  logic [7:0]              flag1_q;
  logic [7:0]              flag2_q;
  logic [7:0]              set1;
  logic [7:0]              set2;
  logic [7:0]              flag1_d;
  logic [7:0]              flag2_d;
  logic                    rdF1;
  logic                    rdF2;
  logic [7:0]              rdData_d;

  function automatic logic hit(input sefb_pkg::sefb_rd_req_t r, input logic [7:0] off);
    hit = r.en && (r.addr == off);
  endfunction

  // Two-flop synchronisers; multi-bit fields may show one mixed sample
  // while changing, which can set a change flag one extra time.
  for (genvar i = 0; i < SW; i++)
  begin : g_sync
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        syncA_q[i] <= 1'b0;
        syncB_q[i] <= 1'b0;
      end
      else
      begin
        syncA_q[i] <= statIn[i];
        syncB_q[i] <= syncA_q[i];
      end
    end
  end

  assign st = sefb_pkg::sefb_stat_in_t'(syncB_q);

  // Previous sample for edge and change detection
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= '0;
    else
      prev_q <= st;
  end

  // Status registers; unlisted bits stay zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat2_q <= `SEFB_RST_VAL; // [RQ21]
      stat3_q <= `SEFB_RST_VAL; // [RQ21]
      fault_q <= `SEFB_RST_VAL; // [RQ21]
    end
    else
    begin
      stat2_q <= `SEFB_RST_VAL; // [RQ24]
      stat2_q[`SEFB_B_PG] <= st.powerGood; // [RQ1]
      stat2_q[`SEFB_B_TS_HI:`SEFB_B_TS_LO] <= st.tsZone; // [RQ2]
      stat3_q <= `SEFB_RST_VAL; // [RQ24]
      stat3_q[`SEFB_B_SYN_HI:`SEFB_B_SYN_LO] <= st.syncState; // [RQ3]
      stat3_q[`SEFB_B_REV] <= st.reverseOn; // [RQ4]
      fault_q <= `SEFB_RST_VAL; // [RQ24]
      fault_q[`SEFB_B_UV] <= st.inUv; // [RQ5]
      fault_q[`SEFB_B_OV] <= st.inOv; // [RQ6]
      fault_q[`SEFB_B_BOC] <= st.batOc; // [RQ7]
      fault_q[`SEFB_B_BOV] <= st.batOv; // [RQ8]
      fault_q[`SEFB_B_TSH] <= st.tshut; // [RQ9]
      fault_q[`SEFB_B_DRV] <= st.drvFault || st.battOnlyAdcOff; // [RQ10] [RQ11]
    end
  end

  // Event detection
  always_comb
  begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[`SEFB_B_ADC] = st.adcDone && !prev_q.adcDone && st.oneShot; // [RQ13]
    set1[`SEFB_B_IAC] = st.iacReg && !prev_q.iacReg; // [RQ14]
    set1[`SEFB_B_VAC] = st.vacReg && !prev_q.vacReg; // [RQ15]
    set1[`SEFB_B_WD] = st.wdExpired && !prev_q.wdExpired; // [RQ16] [RQ23]
    set2[`SEFB_B_PGF] = st.powerGood != prev_q.powerGood; // [RQ17]
    set2[`SEFB_B_TSF] = st.tsZone != prev_q.tsZone; // [RQ18]
    set2[`SEFB_B_REVF] = st.reverseOn != prev_q.reverseOn; // [RQ19]
    set2[`SEFB_B_SYNF] = st.syncState != prev_q.syncState; // [RQ20]
  end

  assign rdF1 = hit(rdReq, `SEFB_OFS_FLAG1);
  assign rdF2 = hit(rdReq, `SEFB_OFS_FLAG2);

  // Set wins over the clearing read so a coincident event is kept
  always_comb
  begin
    flag1_d = (flag1_q & ~{8{rdF1}}) | set1; // [RQ12] [RQ25]
    flag1_d[`SEFB_B_ADC] = flag1_d[`SEFB_B_ADC] && st.oneShot; // [RQ13]
    flag2_d = (flag2_q & ~{8{rdF2}}) | set2; // [RQ12] [RQ25]
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag1_q <= `SEFB_RST_VAL; // [RQ21]
    else
      flag1_q <= flag1_d;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag2_q <= `SEFB_RST_VAL; // [RQ21]
    else
      flag2_q <= flag2_d;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (rdReq.addr)
      `SEFB_OFS_PG_TS:   rdData_d = stat2_q;
      `SEFB_OFS_SYN_REV: rdData_d = stat3_q;
      `SEFB_OFS_FAULT:   rdData_d = fault_q;
      `SEFB_OFS_FLAG1:   rdData_d = flag1_q;
      `SEFB_OFS_FLAG2:   rdData_d = flag2_q;
      default:           rdData_d = `SEFB_RST_VAL; // [RQ24]
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_q  <= `SEFB_RST_VAL;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdValid_q <= rdReq.en;
      if (rdReq.en)
        rdData_q <= rdData_d;
    end
  end

  // One pulse per cycle with any unmasked new event
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqPulse_q <= 1'b0;
    else
      irqPulse_q <= |((set1 & ~flagMask1) | (set2 & ~flagMask2)); // [RQ22]
  end

  // Checks on the read path and flag behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [7:0] off);
    rdReq.en && (rdReq.addr == off);
  endsequence

  sequence s_quiet1;
    !rdF1 && (set1 == 8'h00);
  endsequence

  AST_PG_BIT: assert property ( // [RQ1]
    s_rd(`SEFB_OFS_PG_TS) |=> rdData_q[`SEFB_B_PG] == $past(st.powerGood, 2))
    else $error("Power good bit wrong");

  AST_TS_FIELD: assert property ( // [RQ2]
    s_rd(`SEFB_OFS_PG_TS) |=> rdData_q[6:4] == $past(st.tsZone, 2))
    else $error("Thermistor zone field wrong");

  AST_SYNC_FIELD: assert property ( // [RQ3]
    s_rd(`SEFB_OFS_SYN_REV) |=> rdData_q[5:4] == $past(st.syncState, 2))
    else $error("Sync state field wrong");

  AST_REV_BIT: assert property ( // [RQ4]
    s_rd(`SEFB_OFS_SYN_REV) |=> rdData_q[`SEFB_B_REV] == $past(st.reverseOn, 2))
    else $error("Reverse bit wrong");

  AST_UV_BIT: assert property ( // [RQ5]
    s_rd(`SEFB_OFS_FAULT) |=> rdData_q[`SEFB_B_UV] == $past(st.inUv, 2))
    else $error("Input undervolt bit wrong");

  AST_OV_BIT: assert property ( // [RQ6]
    s_rd(`SEFB_OFS_FAULT) |=> rdData_q[`SEFB_B_OV] == $past(st.inOv, 2))
    else $error("Input overvolt bit wrong");

  AST_BOC_BIT: assert property ( // [RQ7]
    s_rd(`SEFB_OFS_FAULT) |=> rdData_q[`SEFB_B_BOC] == $past(st.batOc, 2))
    else $error("Battery overcurrent bit wrong");

  AST_BOV_BIT: assert property ( // [RQ8]
    s_rd(`SEFB_OFS_FAULT) |=> rdData_q[`SEFB_B_BOV] == $past(st.batOv, 2))
    else $error("Battery overvolt bit wrong");

  AST_TSH_BIT: assert property ( // [RQ9]
    s_rd(`SEFB_OFS_FAULT) |=> rdData_q[`SEFB_B_TSH] == $past(st.tshut, 2))
    else $error("Thermal shutdown bit wrong");

  AST_DRV_BIT: assert property ( // [RQ10]
    s_rd(`SEFB_OFS_FAULT) && !$past(st.battOnlyAdcOff)
      |=> rdData_q[`SEFB_B_DRV] == $past(st.drvFault, 2))
    else $error("Driver supply bit wrong");

  AST_DRV_FORCE: assert property ( // [RQ11]
    st.battOnlyAdcOff ##1 s_rd(`SEFB_OFS_FAULT) |=> rdData_q[`SEFB_B_DRV])
    else $error("Driver supply bit not forced");

  AST_RD_CLEAR: assert property ( // [RQ12]
    rdF2 && (set2 == 8'h00) |=> flag2_q == 8'h00)
    else $error("Flag register not cleared by read");

  AST_ADC_CONT: assert property ( // [RQ13]
    !st.oneShot |=> !flag1_q[`SEFB_B_ADC])
    else $error("Conversion flag set in continuous mode");

  AST_IAC_SET: assert property ( // [RQ14]
    $rose(st.iacReg) |=> flag1_q[`SEFB_B_IAC])
    else $error("Current regulation entry not latched");

  AST_VAC_SET: assert property ( // [RQ15]
    $rose(st.vacReg) |=> flag1_q[`SEFB_B_VAC])
    else $error("Voltage regulation entry not latched");

  AST_WD_SET: assert property ( // [RQ16] [RQ23]
    $rose(st.wdExpired) ##1 s_rd(`SEFB_OFS_FLAG1) |=> rdData_q[`SEFB_B_WD])
    else $error("Watchdog expiry not latched");

  AST_PG_TOGGLE: assert property ( // [RQ17]
    $changed(st.powerGood) |=> flag2_q[`SEFB_B_PGF])
    else $error("Power good toggle not latched");

  AST_TS_CHANGE: assert property ( // [RQ18]
    $changed(st.tsZone) |=> flag2_q[`SEFB_B_TSF])
    else $error("Zone change not latched");

  AST_REV_TOGGLE: assert property ( // [RQ19]
    $changed(st.reverseOn) |=> flag2_q[`SEFB_B_REVF])
    else $error("Reverse toggle not latched");

  AST_SYN_CHANGE: assert property ( // [RQ20]
    $changed(st.syncState) |=> flag2_q[`SEFB_B_SYNF])
    else $error("Sync change not latched");

  AST_RST_ZERO: assert property ( // [RQ21]
    $rose(rst_n) |-> (flag1_q | flag2_q | stat2_q | stat3_q | fault_q) == 8'h00)
    else $error("Register not zero after reset");

  AST_IRQ_PULSE: assert property ( // [RQ22]
    ((set1 & ~flagMask1) | (set2 & ~flagMask2)) != 8'h00 |=> irqPulse_q ##1 1'b1)
    else $error("Unmasked event gave no pulse");

  AST_IRQ_MASKED: assert property ( // [RQ22]
    ((set1 & ~flagMask1) | (set2 & ~flagMask2)) == 8'h00 |=> !irqPulse_q)
    else $error("Pulse without unmasked event");

  AST_RSVD_ZERO: assert property ( // [RQ24]
    s_rd(`SEFB_OFS_SYN_REV)
      |=> {rdData_q[7:6], rdData_q[3], rdData_q[1:0]} == 5'h00)
    else $error("Reserved bits not zero");

  AST_UNMAPPED: assert property ( // [RQ24]
    rdReq.en && (rdReq.addr < `SEFB_OFS_PG_TS) |=> rdData_q == 8'h00)
    else $error("Unmapped address not zero");

  AST_FLAG_HOLD: assert property ( // [RQ25]
    flag1_q[`SEFB_B_IAC] && st.oneShot ##0 s_quiet1 [*2]
      |=> flag1_q[`SEFB_B_IAC])
    else $error("Flag lost without a read");

  AST_COINCIDE: assert property ( // [RQ25]
    rdF2 |=> flag2_q == $past(set2))
    else $error("Event during read not kept");

  // Reserved positions have no source, so one seen set means a
  // miswired field rather than a live event.
  AST_PGTS_RSVD: assert property ( // [RQ24]
    s_rd(`SEFB_OFS_PG_TS) |=> rdData_q[3:0] == 4'h0)
    else $error("Reserved status bits not zero");

  AST_FAULT_RSVD: assert property ( // [RQ24]
    s_rd(`SEFB_OFS_FAULT) |=> {rdData_q[2], rdData_q[0]} == 2'h0)
    else $error("Reserved fault bits not zero");

  AST_FLAG1_RSVD: assert property ( // [RQ24]
    {flag1_q[4], flag1_q[2:0]} == 4'h0)
    else $error("Reserved first flag bits set");

  AST_FLAG2_RSVD: assert property ( // [RQ24]
    {flag2_q[6:5], flag2_q[2], flag2_q[0]} == 4'h0)
    else $error("Reserved second flag bits set");

  AST_UNMAPPED_HI: assert property ( // [RQ24]
    rdReq.en && (rdReq.addr > `SEFB_OFS_FLAG2) |=> rdData_q == 8'h00)
    else $error("High unmapped address not zero");

  AST_F1_CLEAR: assert property ( // [RQ12]
    rdF1 && (set1 == 8'h00) |=> flag1_q == 8'h00)
    else $error("First flag register not cleared by read");

  AST_F1_COINCIDE: assert property ( // [RQ25]
    rdF1 |=> flag1_q == $past(set1))
    else $error("Event during first flag read not kept");

  AST_PGF_HOLD: assert property ( // [RQ25]
    flag2_q[`SEFB_B_PGF] && !rdF2 |=> flag2_q[`SEFB_B_PGF])
    else $error("Toggle flag lost without a read");

  AST_WD_HOLD: assert property ( // [RQ25]
    flag1_q[`SEFB_B_WD] && !rdF1 |=> flag1_q[`SEFB_B_WD])
    else $error("Watchdog flag lost without a read");

endmodule // sefb_status_flag_bank

`default_nettype wire

// *** test/sefb_host_model.sv ***
// Host side model: issues single reads on the bank's internal read port.
// Assumes rd() is called just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none

module sefb_host_model (
  input  wire logic                   core_clk,
  output var  sefb_pkg::sefb_rd_req_t rdReq,
  input  wire logic [7:0]             rdData_q,
  input  wire logic                   rdValid_q
);
  initial rdReq = '0;

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    rdReq.en = 1'b1;
    rdReq.addr = a;
    @(posedge core_clk);
    #1;
    rdReq.en = 1'b0;
    // Idle address flips so a stale address never looks like a request
    rdReq.addr = ~a;
    while (rdValid_q !== 1'b1 && n < 4)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    ok = (rdValid_q === 1'b1) && (n == 0);
    d = rdData_q;
    // Idle cycle keeps the strobes of back-to-back reads apart
    @(posedge core_clk);
    #1;
  endtask
endmodule // sefb_host_model

`default_nettype wire

// *** test/sefb_status_flag_bank_tb.sv ***
// Self-checking bench for the status and event flag bank.
// Assumes the host model file and the bank's package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module sefb_status_flag_bank_tb;
  logic                    core_clk;
  logic                    rst_n;
  sefb_pkg::sefb_stat_in_t statIn;
  sefb_pkg::sefb_stat_in_t prevIn;
  sefb_pkg::sefb_rd_req_t  rdReq;
  logic [7:0]              flagMask1;
  logic [7:0]              flagMask2;
  logic [7:0]              rdData_q;
  logic                    rdValid_q;
  logic                    irqPulse_q;
  logic [7:0]              lfsrState;
  logic [23:0]             r;
  logic                    expPulse;
  logic [7:0]              addrs [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h21, 8'hFF};
  int                      bad_count;
  int                      samples_checked;
  int                      pulseCount = 0;
  int                      pulseBase;

  sefb_status_flag_bank DUT (.core_clk(core_clk), .rst_n(rst_n), .statIn(statIn),
    .rdReq(rdReq), .flagMask1(flagMask1), .flagMask2(flagMask2), .rdData_q(rdData_q),
    .rdValid_q(rdValid_q), .irqPulse_q(irqPulse_q));

  sefb_host_model HOST (.core_clk(core_clk), .rdReq(rdReq), .rdData_q(rdData_q),
    .rdValid_q(rdValid_q));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Samples the pulse as launched by the previous edge
  always @(posedge core_clk) if (irqPulse_q === 1'b1) pulseCount++;

  function automatic logic [7:0] nextRand();
    lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
    return lfsrState;
  endfunction

  function automatic logic [7:0] expStat(logic [7:0] a, sefb_pkg::sefb_stat_in_t s);
    case (a)
      8'h22: return {s.powerGood, s.tsZone, 4'h0};
      8'h23: return {2'h0, s.syncState, 1'h0, s.reverseOn, 2'h0};
      8'h24: return {s.inUv, s.inOv, s.batOc, s.batOv, s.tshut, 1'h0,
                     s.drvFault | s.battOnlyAdcOff, 1'h0};
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] expFlag1(sefb_pkg::sefb_stat_in_t o, sefb_pkg::sefb_stat_in_t n);
    return {n.oneShot & n.adcDone & ~o.adcDone, n.iacReg & ~o.iacReg, n.vacReg & ~o.vacReg,
            1'h0, n.wdExpired & ~o.wdExpired, 3'h0};
  endfunction

  function automatic logic [7:0] expFlag2(sefb_pkg::sefb_stat_in_t o, sefb_pkg::sefb_stat_in_t n);
    return {o.powerGood != n.powerGood, 2'h0, o.tsZone != n.tsZone,
            o.reverseOn != n.reverseOn, 1'h0, o.syncState != n.syncState, 1'h0};
  endfunction

  task automatic check(logic [7:0] got, logic [7:0] exp, string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rdChk(logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    HOST.rd(a, d, ok);
    check({7'h00, ok}, 8'h01, "read answer");
    check(d, e, "read data");
  endtask

  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #500000;
    bad_count++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    statIn = '0;
    prevIn = '0;
    flagMask1 = 8'h00;
    flagMask2 = 8'h00;
    lfsrState = 8'h5A;
    bad_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    foreach (addrs[i]) rdChk(addrs[i], 8'h00);
    repeat (40)
    begin
      prevIn = statIn;
      r = {nextRand(), nextRand(), nextRand()};
      statIn = sefb_pkg::sefb_stat_in_t'(r[18:0]);
      statIn.tsZone = sefb_pkg::sefb_ts_zone_t'(3'(r[21:19] % 5));
      statIn.syncState = sefb_pkg::sefb_sync_t'(2'(r[23:22] % 3));
      flagMask1 = nextRand();
      flagMask2 = nextRand();
      pulseBase = pulseCount;
      settle();
      expPulse = |((expFlag1(prevIn, statIn) & ~flagMask1) |
                   (expFlag2(prevIn, statIn) & ~flagMask2));
      check(8'(pulseCount - pulseBase), {7'h00, expPulse}, "irq pulses");
      rdChk(8'h25, expFlag1(prevIn, statIn));
      rdChk(8'h26, expFlag2(prevIn, statIn));
      rdChk(8'h25, 8'h00);
      rdChk(8'h26, 8'h00);
      rdChk(8'h22, expStat(8'h22, statIn));
      rdChk(8'h23, expStat(8'h23, statIn));
      rdChk(8'h24, expStat(8'h24, statIn));
      rdChk(8'hFF, 8'h00);
    end
    // Flag must outlive its cause; start low so the rise is a real one
    statIn.iacReg = 1'b0;
    settle();
    statIn.iacReg = 1'b1;
    settle();
    statIn.iacReg = 1'b0;
    settle();
    rdChk(8'h25, 8'h40);
    // Event lands on the very edge of the clearing read
    statIn.powerGood = ~statIn.powerGood;
    repeat (2) @(posedge core_clk);
    #1;
    rdChk(8'h26, 8'h00);
    rdChk(8'h26, 8'h80);
    final_report();
  end
endmodule // sefb_status_flag_bank_tb

`default_nettype wire
